// ### rtl/spc_pkg.sv
// Constants shared by the six channel pulse counter and its synchroniser.
// How it works
// - Each 16-bit counter adds one per detected rising edge on its input.
// - A counter at FFFFH wraps to 0000H on the next counted edge.
// - Hardware reset leaves all six counter values untouched.
// - Codes 0 and 8 answer with the sixteen general input pin states.
// - Codes 1 to 6 answer with the value of channels 1 to 6.
// - Codes 9 to 14 clear channels 1 to 6 and answer zero.
// - Codes 7 and 15 answer with the serial identity register.
// - Bypass strap high routes each raw pulse input to its edge latch.
// - Edge latch samples at drive clock over eight; rising output counts.
// - Bypass strap low feeds the filter output to the edge latch.
// - Filter is a two-stage shift register stepped by its filter clock.
// - Filter output follows only after two equal consecutive filter samples.
// - Filter clocks a, b, c serve inputs 0-1, 2-3 and 4-5.
package spc_pkg;
   localparam int SPC_CHANNELS = 6;
   localparam int SPC_CNT_W = 16;
   localparam int SPC_CMD_W = 4;
   localparam int SPC_GPI_W = 16;
   localparam int SPC_IDX_W = 3;
   localparam int SPC_FCLK_GROUPS = 3;
   localparam int SPC_CH_PER_FCLK = 2;
   localparam int SPC_DIV_W = 3;
   localparam logic [SPC_DIV_W-1:0] SPC_DIV_LAST = 3'h7;
   localparam logic [SPC_DIV_W-1:0] SPC_DIV_ZERO = 3'h0;
   localparam logic [SPC_DIV_W-1:0] SPC_DIV_STEP = 3'h1;
   localparam logic [SPC_CMD_W-1:0] SPC_CMD_GPI_A = 4'h0;
   localparam logic [SPC_CMD_W-1:0] SPC_CMD_GPI_B = 4'h8;
   localparam logic [SPC_CMD_W-1:0] SPC_CMD_READ_FIRST = 4'h1;
   localparam logic [SPC_CMD_W-1:0] SPC_CMD_READ_LAST = 4'h6;
   localparam logic [SPC_CMD_W-1:0] SPC_CMD_SID_A = 4'h7;
   localparam logic [SPC_CMD_W-1:0] SPC_CMD_SID_B = 4'hF;
   localparam logic [SPC_CMD_W-1:0] SPC_CMD_CLR_FIRST = 4'h9;
   localparam logic [SPC_CMD_W-1:0] SPC_CMD_CLR_LAST = 4'hE;
   localparam logic [SPC_CNT_W-1:0] SPC_CNT_ZERO = 16'h0000;
   localparam logic [SPC_CNT_W-1:0] SPC_CNT_ONE = 16'h0001;
   localparam logic [SPC_CNT_W-1:0] SPC_CNT_MAX = 16'hFFFF;
   localparam logic SPC_LATCH_RST = 1'b1;
   localparam logic SPC_BIT_ZERO = 1'b0;
endpackage

// ### rtl/spc_sync.sv
// Three-stage input synchroniser whose output moves once stages two and three agree.
`timescale 1ns/1ps
module spc_sync
   import spc_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic ce_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] held_q;
   wire logic [WIDTH-1:0] agree;
   wire logic [WIDTH-1:0] held_d;

   // Stage one feeds only stage two; only the later stages are compared.
   assign agree = ~(s2_q ^ s3_q);
   assign held_d = (agree & s3_q) | (~agree & held_q);
   assign sync_out = held_q;

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         held_q <= '0;
      end else if (ce_in) begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         held_q <= held_d;
      end
   end
endmodule // spc_sync

// ### rtl/spc_top.sv
// Six channel pulse counter with digital filters, edge latches and command decode.
`timescale 1ns/1ps
module spc_top
   import spc_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic ce_in,
   input wire logic [SPC_CHANNELS-1:0] pulse_count_inputs_in,
   input wire logic filter_bypass_strap_in,
   input wire logic filter_clock_a_in,
   input wire logic filter_clock_b_in,
   input wire logic filter_clock_c_in,
   input wire logic [SPC_GPI_W-1:0] general_input_pins_in,
   input wire logic [SPC_CNT_W-1:0] serial_identity_shift_reg_in,
   input wire logic cmd_valid_in,
   input wire logic [SPC_CMD_W-1:0] cmd_code_in,
   output logic resp_valid_out,
   output logic [SPC_CNT_W-1:0] resp_data_out
);
   wire logic [SPC_CHANNELS-1:0] pin_s;
   wire logic [SPC_FCLK_GROUPS-1:0] fclk_s;
   wire logic bypass_s;
   wire logic [SPC_GPI_W-1:0] gpi_s;
   logic [SPC_FCLK_GROUPS-1:0] fclk_prev_q;
   wire logic [SPC_FCLK_GROUPS-1:0] fclk_rise;
   logic [SPC_CHANNELS-1:0] stage1_q;
   logic [SPC_CHANNELS-1:0] stage2_q;
   logic [SPC_CHANNELS-1:0] filt_q;
   wire logic [SPC_CHANNELS-1:0] sel;
   logic [SPC_CHANNELS-1:0] latch_q;
   wire logic [SPC_CHANNELS-1:0] inc;
   wire logic [SPC_CHANNELS-1:0] clr_hit;
   logic [SPC_DIV_W-1:0] div_q;
   wire logic tick;
   logic [SPC_CNT_W-1:0] cnt_q [SPC_CHANNELS];
   logic [SPC_CNT_W-1:0] cnt_d [SPC_CHANNELS];
   wire logic is_gpi;
   wire logic is_read;
   wire logic is_clr;
   wire logic is_sid;
   wire logic [SPC_CMD_W-1:0] rd_off;
   wire logic [SPC_CMD_W-1:0] clr_off;
   wire logic [SPC_IDX_W-1:0] rd_idx;
   wire logic [SPC_IDX_W-1:0] clr_idx;
   wire logic [SPC_CNT_W-1:0] rd_val;
   wire logic [SPC_CNT_W-1:0] resp_d;
   wire logic [SPC_FCLK_GROUPS-1:0] fclk_raw;

   assign fclk_raw = {filter_clock_c_in, filter_clock_b_in, filter_clock_a_in};

   // Every pin and filter clock is foreign to the drive clock, so all pass a synchroniser.
   spc_sync #(.WIDTH(SPC_CHANNELS)) u_sync_pin (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .ce_in(ce_in),
      .async_in(pulse_count_inputs_in),
      .sync_out(pin_s)
   );
   spc_sync #(.WIDTH(SPC_FCLK_GROUPS)) u_sync_fclk (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .ce_in(ce_in),
      .async_in(fclk_raw),
      .sync_out(fclk_s)
   );
   spc_sync #(.WIDTH(1)) u_sync_strap (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .ce_in(ce_in),
      .async_in(filter_bypass_strap_in),
      .sync_out(bypass_s)
   );
   spc_sync #(.WIDTH(SPC_GPI_W)) u_sync_gpi (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .ce_in(ce_in),
      .async_in(general_input_pins_in),
      .sync_out(gpi_s)
   );

   // A filter clock steps its filters on its rising edge as seen after synchronising.
   // The filter clock must therefore stay well below the drive clock rate.
   assign fclk_rise = fclk_s & ~fclk_prev_q;

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         fclk_prev_q <= '0;
      end else if (ce_in) begin
         fclk_prev_q <= fclk_s;
      end
   end

   // Latch strobe at one eighth of the drive clock.
   assign tick = (div_q == SPC_DIV_LAST);

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         div_q <= SPC_DIV_ZERO;
      end else if (ce_in) begin
         div_q <= div_q + SPC_DIV_STEP;
      end
   end

   // Command decode.
   assign is_gpi = (cmd_code_in == SPC_CMD_GPI_A) || (cmd_code_in == SPC_CMD_GPI_B);
   assign is_sid = (cmd_code_in == SPC_CMD_SID_A) || (cmd_code_in == SPC_CMD_SID_B);
   assign is_read = (cmd_code_in >= SPC_CMD_READ_FIRST) && (cmd_code_in <= SPC_CMD_READ_LAST);
   assign is_clr = (cmd_code_in >= SPC_CMD_CLR_FIRST) && (cmd_code_in <= SPC_CMD_CLR_LAST);
   assign rd_off = cmd_code_in - SPC_CMD_READ_FIRST;
   assign clr_off = cmd_code_in - SPC_CMD_CLR_FIRST;
   assign rd_idx = rd_off[SPC_IDX_W-1:0];
   assign clr_idx = clr_off[SPC_IDX_W-1:0];
   assign rd_val = (is_read && (rd_idx < SPC_IDX_W'(SPC_CHANNELS))) ? cnt_q[rd_idx] : SPC_CNT_ZERO;
   assign resp_d = is_gpi ? gpi_s :
                   is_sid ? serial_identity_shift_reg_in :
                   is_read ? rd_val :
                   SPC_CNT_ZERO;

   genvar gi;
   generate
      for (gi = 0; gi < SPC_CHANNELS; gi++) begin : g_ch
         localparam int GRP = gi / SPC_CH_PER_FCLK;

         // Filter stages live in the drive domain, fed by synchronised pins.
         always_ff @(posedge core_clk_in) begin
            if (srst_in) begin
               stage1_q[gi] <= SPC_BIT_ZERO;
               stage2_q[gi] <= SPC_BIT_ZERO;
               filt_q[gi] <= SPC_BIT_ZERO;
            end else if (ce_in && fclk_rise[GRP]) begin
               stage1_q[gi] <= pin_s[gi];
               stage2_q[gi] <= stage1_q[gi];
               if (stage1_q[gi] == stage2_q[gi]) begin
                  filt_q[gi] <= stage1_q[gi];
               end
            end
         end

         assign sel[gi] = bypass_s ? pin_s[gi] : filt_q[gi];

         // The latch starts high after reset so a level already high is not counted in bypass mode.
         always_ff @(posedge core_clk_in) begin
            if (srst_in) begin
               latch_q[gi] <= SPC_LATCH_RST;
            end else if (ce_in && tick) begin
               latch_q[gi] <= sel[gi];
            end
         end

         assign inc[gi] = ~srst_in & tick & sel[gi] & ~latch_q[gi];
         assign clr_hit[gi] = ~srst_in & cmd_valid_in & is_clr & (clr_idx == SPC_IDX_W'(gi));

         // A clear meeting an edge in one cycle leaves one, so the edge is not lost.
         assign cnt_d[gi] = (clr_hit[gi] ? SPC_CNT_ZERO : cnt_q[gi]) +
                            (inc[gi] ? SPC_CNT_ONE : SPC_CNT_ZERO);

         // No reset here: the counts must survive a hardware reset.
         always_ff @(posedge core_clk_in) begin
            if (ce_in) begin
               cnt_q[gi] <= cnt_d[gi];
            end
         end

         property p_count_step;
            @(posedge core_clk_in) disable iff (srst_in)
            (ce_in && inc[gi] && !clr_hit[gi]) |=> (cnt_q[gi] == $past(cnt_q[gi]) + SPC_CNT_ONE);
         endproperty
         a_count_step: assert property (p_count_step) else $error("count did not step");

         property p_wrap;
            @(posedge core_clk_in) disable iff (srst_in)
            (ce_in && inc[gi] && !clr_hit[gi] && cnt_q[gi] == SPC_CNT_MAX)
               |=> (cnt_q[gi] == SPC_CNT_ZERO);
         endproperty
         a_wrap: assert property (p_wrap) else $error("counter did not wrap");

         // Counts power up unknown, so retention is checked with a four-state compare.
         property p_hold_in_reset;
            @(posedge core_clk_in) srst_in |=> (cnt_q[gi] === $past(cnt_q[gi]));
         endproperty
         a_hold_in_reset: assert property (p_hold_in_reset) else $error("reset changed count");

         // A clear may land on any cycle, so only edge counting is tied to the strobe.
         property p_latch_only_on_tick;
            @(posedge core_clk_in) disable iff (srst_in)
            (ce_in && !tick && !clr_hit[gi])
               |=> (latch_q[gi] == $past(latch_q[gi])) && (cnt_q[gi] === $past(cnt_q[gi]));
         endproperty
         a_latch_only_on_tick: assert property (p_latch_only_on_tick) else $error("off-tick change");

         property p_source_select;
            @(posedge core_clk_in) disable iff (srst_in)
            (ce_in && tick) |=> (latch_q[gi] == ($past(bypass_s) ? $past(pin_s[gi]) : $past(filt_q[gi])));
         endproperty
         a_source_select: assert property (p_source_select) else $error("wrong latch source");

         property p_filter_two_samples;
            @(posedge core_clk_in) disable iff (srst_in)
            $changed(filt_q[gi]) |-> ($past(stage1_q[gi]) == $past(stage2_q[gi])) && $past(fclk_rise[GRP]);
         endproperty
         a_filter_two_samples: assert property (p_filter_two_samples) else $error("filter glitch");
      end
   endgenerate

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         resp_valid_out <= SPC_BIT_ZERO;
         resp_data_out <= SPC_CNT_ZERO;
      end else if (ce_in) begin
         resp_valid_out <= cmd_valid_in;
         if (cmd_valid_in) begin
            resp_data_out <= resp_d;
         end
      end
   end

   property p_gpi_answer;
      @(posedge core_clk_in) disable iff (srst_in)
      (ce_in && cmd_valid_in && is_gpi) |=> resp_valid_out && (resp_data_out == $past(gpi_s));
   endproperty
   a_gpi_answer: assert property (p_gpi_answer) else $error("bad input-pin answer");

   property p_read_answer;
      @(posedge core_clk_in) disable iff (srst_in)
      (ce_in && cmd_valid_in && is_read) |=> resp_valid_out && (resp_data_out == $past(rd_val));
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("bad counter answer");

   property p_clear;
      @(posedge core_clk_in) disable iff (srst_in)
      (ce_in && cmd_valid_in && is_clr) |=> resp_valid_out && (resp_data_out == SPC_CNT_ZERO)
         && (cnt_q[$past(clr_idx)] <= SPC_CNT_ONE);
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed");

   property p_sid_answer;
      @(posedge core_clk_in) disable iff (srst_in)
      (ce_in && cmd_valid_in && is_sid)
         |=> resp_valid_out && (resp_data_out == $past(serial_identity_shift_reg_in));
   endproperty
   a_sid_answer: assert property (p_sid_answer) else $error("bad identity answer");

   c_count: cover property (@(posedge core_clk_in) disable iff (srst_in) inc[0]);
   c_wrap: cover property (@(posedge core_clk_in) disable iff (srst_in)
      inc[5] && cnt_q[5] == SPC_CNT_MAX);
   c_clear: cover property (@(posedge core_clk_in) disable iff (srst_in) cmd_valid_in && is_clr);
   c_filtered: cover property (@(posedge core_clk_in) disable iff (srst_in)
      !bypass_s && $rose(filt_q[2]));
endmodule // spc_top

// ### verif/spc_master_model.sv
// Model of the network master that issues command codes and collects the answers.
`timescale 1ns/1ps
module spc_master_model
   import spc_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic resp_valid_in,
   input wire logic [SPC_CNT_W-1:0] resp_data_in,
   output logic cmd_valid_out,
   output logic [SPC_CMD_W-1:0] cmd_code_out
);
   initial begin
      cmd_valid_out = 1'b0;
      cmd_code_out = 4'h0;
   end

   // One command per call; the answer is taken in the cycle after the command edge.
   task automatic send(input logic [SPC_CMD_W-1:0] code, output logic vld,
                       output logic [SPC_CNT_W-1:0] data);
      @(negedge core_clk_in);
      cmd_valid_out = 1'b1;
      cmd_code_out = code;
      @(posedge core_clk_in);
      @(negedge core_clk_in);
      cmd_valid_out = 1'b0;
      // An idle code bus shows the inverse so a stale code can never look valid.
      cmd_code_out = ~code;
      vld = resp_valid_in;
      data = resp_data_in;
   endtask
endmodule // spc_master_model

// ### verif/test_six_channel_pulse_counter.sv
// Self-checking testbench for the six channel pulse counter.
`timescale 1ns/1ps
module test_six_channel_pulse_counter
   import spc_pkg::*;
;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic strap = 1'b1;
   logic ce = 1'b1;
   logic [2:0] fclk = 3'h0;
   logic [5:0] pins = 6'h00;
   logic [15:0] gpi = 16'h0000;
   logic [15:0] sid = 16'h0000;
   logic cmd_valid;
   logic [3:0] cmd_code;
   logic resp_valid;
   logic [15:0] resp_data;
   logic [15:0] expc [6];
   int bad_count = 0;
   int checked = 0;

   always #2.5 core_clk = ~core_clk;

   spc_top spc_top_inst (.core_clk_in(core_clk), .srst_in(srst), .ce_in(ce),
      .pulse_count_inputs_in(pins), .filter_bypass_strap_in(strap),
      .filter_clock_a_in(fclk[0]), .filter_clock_b_in(fclk[1]), .filter_clock_c_in(fclk[2]),
      .general_input_pins_in(gpi), .serial_identity_shift_reg_in(sid),
      .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code),
      .resp_valid_out(resp_valid), .resp_data_out(resp_data));

   spc_master_model spc_master_model_inst (.core_clk_in(core_clk), .resp_valid_in(resp_valid),
      .resp_data_in(resp_data), .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code));

   task automatic complete_run();
      $display("Counts: checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic run_cmd(input logic [3:0] code, input logic [15:0] exp);
      logic v;
      logic [15:0] d;
      spc_master_model_inst.send(code, v, d);
      chk_bit($sformatf("answer strobe code %0d", code), 1'b1, v);
      chk16($sformatf("answer data code %0d", code), exp, d);
   endtask

   task automatic read_all();
      for (int i = 0; i < 6; i++) begin
         run_cmd(4'(i + 1), expc[i]);
      end
   endtask

   // Counters power up undefined, so the bypass and filter test sequences start from cleared values.
   task automatic clear_all();
      for (int i = 0; i < 6; i++) begin
         run_cmd(4'(i + 9), 16'h0000);
         expc[i] = 16'h0000;
      end
   endtask

   // Levels of 20 drive cycles stay clear of the eight-cycle sampling limit.
   task automatic pulse(input logic [5:0] m);
      @(negedge core_clk);
      pins = m;
      repeat (20) @(negedge core_clk);
      pins = 6'h00;
      repeat (20) @(negedge core_clk);
   endtask

   // Filter clocks run far below the drive clock so each edge survives resynchronising.
   task automatic ftick(input logic [2:0] m, input int n);
      repeat (n) begin
         @(negedge core_clk);
         fclk = m;
         repeat (16) @(negedge core_clk);
         fclk = 3'h0;
         repeat (16) @(negedge core_clk);
      end
   endtask

   task automatic t_bypass();
      clear_all();
      for (int k = 0; k < 6; k++) begin
         pulse(6'h3F << k);
         for (int i = k; i < 6; i++) expc[i] = expc[i] + 16'h0001;
      end
      read_all();
      $display("Test bypass counting done");
   endtask

   task automatic t_reset();
      @(negedge core_clk);
      pins = 6'h3F;
      srst = 1'b1;
      repeat (3) @(negedge core_clk);
      srst = 1'b0;
      repeat (20) @(negedge core_clk);
      pins = 6'h00;
      repeat (20) @(negedge core_clk);
      read_all();
      $display("Test reset retention done");
   endtask

   // A low clock enable freezes the synchronisers, so a pulse meanwhile is never counted.
   task automatic t_freeze();
      ce = 1'b0;
      pulse(6'h3F);
      ce = 1'b1;
      repeat (8) @(negedge core_clk);
      read_all();
      $display("Test clock enable freeze done");
   endtask

   task automatic t_info();
      gpi = 16'hA5C3;
      sid = 16'h3C96;
      repeat (6) @(negedge core_clk);
      run_cmd(4'h0, gpi);
      run_cmd(4'h8, gpi);
      run_cmd(4'h7, sid);
      run_cmd(4'hF, sid);
      $display("Test general pins and identity done");
   endtask

   task automatic t_filter();
      strap = 1'b0;
      ftick(3'h7, 4);
      clear_all();
      for (int g = 0; g < 3; g++) begin
         pins = 6'h3F;
         ftick(3'(1 << g), 4);
         pins = 6'h00;
         ftick(3'(1 << g), 4);
         expc[2 * g] = expc[2 * g] + 16'h0001;
         expc[2 * g + 1] = expc[2 * g + 1] + 16'h0001;
         read_all();
      end
      // A high level seen by a single filter sample must not be counted.
      pins = 6'h3F;
      ftick(3'h7, 1);
      pins = 6'h00;
      ftick(3'h7, 4);
      read_all();
      $display("Test filtered counting done");
   endtask

   initial begin
      repeat (3) @(negedge core_clk);
      srst = 1'b0;
      repeat (8) @(negedge core_clk);
      t_bypass();
      t_reset();
      t_freeze();
      t_info();
      t_filter();
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      complete_run();
   end
endmodule // test_six_channel_pulse_counter
